// file: hw/cec_conv_ctrl.sv
// One converter's enable selection, delays and start-up timeout.
`timescale 1ns/1ns
`default_nettype none
module cec_conv_ctrl #(
    parameter int STEP_CYC = cec_pkg::DELAY_STEP_CYC,
    parameter int TIMEOUT_CYC = cec_pkg::SC_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic allowed,
    input wire logic on_bit,
    input wire logic [1:0] pin_select,
    input wire logic [2:0] pins_sync,
    input wire logic [3:0] on_delay,
    input wire logic [3:0] off_delay,
    input wire logic above_level,
    // Results
    output logic conv_on,
    output logic timeout_pulse
);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int SW = $clog2(STEP_CYC + 1);
    logic pin_level;
    logic pin_prev_r;
    logic pin_mode;
    logic on_r;
    logic faulted_r;
    logic [3:0] steps_r;
    logic [SW-1:0] tick_r;
    logic pending_r;
    logic pend_target_r;
    logic [TW-1:0] sc_cnt_r;
    logic tick;
    logic rise;
    logic fall;
    logic req;
    logic sc_expire;

    assign pin_mode = (pin_select != cec_pkg::SEL_REG);
    assign pin_level = (pin_select == cec_pkg::SEL_PIN_A) ? pins_sync[0] :
                       (pin_select == cec_pkg::SEL_PIN_B) ? pins_sync[1] :
                       pins_sync[2];
    assign rise = pin_mode && pin_level && !pin_prev_r;
    assign fall = pin_mode && !pin_level && pin_prev_r;
    assign tick = (tick_r == SW'(STEP_CYC - 1));
    assign req = on_bit && allowed && !faulted_r;
    assign sc_expire = on_r && !above_level
                       && (sc_cnt_r == TW'(TIMEOUT_CYC - 1));

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_prev_r <= 1'b0;
            tick_r <= '0;
            steps_r <= 4'h0;
            pending_r <= 1'b0;
            pend_target_r <= 1'b0;
            on_r <= 1'b0;
            faulted_r <= 1'b0;
            sc_cnt_r <= '0;
            timeout_pulse <= 1'b0;
        end else begin
            pin_prev_r <= pin_level;
            tick_r <= tick ? '0 : tick_r + SW'(1);
            timeout_pulse <= sc_expire;
            if (!on_bit || !allowed) begin
                faulted_r <= 1'b0;
            end else if (sc_expire) begin
                faulted_r <= 1'b1;
            end
            if (!req) begin
                on_r <= 1'b0;
                pending_r <= 1'b0;
            end else if (!pin_mode) begin
                on_r <= 1'b1;
                pending_r <= 1'b0;
            end else if (rise || fall) begin
                pending_r <= 1'b1;
                pend_target_r <= rise;
                steps_r <= rise ? on_delay : off_delay;
            end else if (pending_r && steps_r == 4'h0) begin
                on_r <= pend_target_r;
                pending_r <= 1'b0;
            end else if (pending_r && tick) begin
                steps_r <= steps_r - 4'h1;
            end
            if (!on_r || above_level) begin
                sc_cnt_r <= '0;
            end else begin
                sc_cnt_r <= sc_cnt_r + TW'(1);
            end
        end
    end
    assign conv_on = on_r;
endmodule // cec_conv_ctrl
`default_nettype wire

// file: hw/cec_pkg.sv
// Shared constants for the converter enable and clock control block.
package cec_pkg;
    // ----------------------------------------
    // Pin select codes
    // ----------------------------------------
    localparam logic [1:0] SEL_REG = 2'h0;
    localparam logic [1:0] SEL_PIN_A = 2'h1;
    localparam logic [1:0] SEL_PIN_B = 2'h2;
    localparam logic [1:0] SEL_PIN_C = 2'h3;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int SC_TIMEOUT_US = 1000;
    localparam int SC_TIMEOUT_CYC = SC_TIMEOUT_US * (CLK_HZ / 1000000);
    localparam int DELAY_STEP_US = 500;
    localparam int DELAY_STEP_CYC = DELAY_STEP_US * (CLK_HZ / 1000000);
    localparam int MEAS_WINDOW_US = 100;
    localparam int MEAS_WINDOW_CYC = MEAS_WINDOW_US * (CLK_HZ / 1000000);
    // Sync clock limits: -30 % and +10 % of nominal, counted over the window.
    localparam int FREQ_LO_PCT = 70;
    localparam int FREQ_HI_PCT = 110;
    localparam logic [4:0] FREQ_RESET = 5'h01;
    localparam logic STEPUP_DISCHARGE_RESET = 1'b1;
    // ----------------------------------------
    // Device operating states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_CFG_READ = 2'b01,
        ST_STANDBY = 2'b10,
        ST_ACTIVE = 2'b11
    } cec_state_t;
    localparam int CFG_READ_CYC = 64;
endpackage

// file: hw/cec_top.sv
// Converter enable, power-good flags and sync clock control.
// Contract
// - Enable bit 0 keeps converter off; bit 1 with select 00 runs it.
// - Select codes 01, 10, 11 pick pins A, B, C; pin level gives on.
// - Pin rising edge waits the four-bit start-up delay before turning on.
// - Pin falling edge waits the four-bit shut-down delay before off.
// - Delays apply only under pin control; register enabling acts at once.
// - Step-down converters may be enabled only in standby or active.
// - Output not above low level within 1 ms disables it, sets flag.
// - Output rising above undervoltage threshold sets power-good flag.
// - One bit picks undervoltage only or undervoltage plus overvoltage.
// - Rise mask suppresses the flag when the output becomes valid.
// - Output becoming invalid also sets flag; fall mask suppresses it.
// - In window mode masks apply to crossings of either threshold.
// - Valid status bit always mirrors output validity, masks ignored.
// - Frequency dither on all converters only while sync enable is 0.
// - Five-bit field sets expected sync frequency, 1 to 24 MHz.
// - Sync clock valid only within minus 30 to plus 10 percent.
// - Sync disabled: internal clock, no flag; enabled: flag on change.
// - Sync enabled and clock absent at state transitions raises flag; code checks only config read to standby and standby to active.
// - A mask bit keeps the sync flag off the interrupt output.
// - After reset release and configuration read, enter standby.
// - Discharge bit, default set, pulls boost output down when off.
`timescale 1ns/1ns
`default_nettype none
module cec_top #(
    parameter int STEP_CYC = cec_pkg::DELAY_STEP_CYC,
    parameter int TIMEOUT_CYC = cec_pkg::SC_TIMEOUT_CYC,
    parameter int MEAS_CYC = cec_pkg::MEAS_WINDOW_CYC,
    parameter int CFG_CYC = cec_pkg::CFG_READ_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_input_low,
    // Enable pins
    input wire logic enable_pin_a,
    input wire logic enable_pin_b,
    input wire logic enable_pin_c,
    // Step-down control, one field per converter
    input wire logic [1:0] stepdown_on_bit,
    input wire logic [3:0] stepdown_pin_select,
    input wire logic [7:0] stepdown_on_delay,
    input wire logic [7:0] stepdown_off_delay,
    // Step-up control
    input wire logic stepup_on_bit,
    input wire logic [1:0] stepup_pin_select,
    input wire logic [3:0] stepup_on_delay,
    input wire logic [3:0] stepup_off_delay,
    input wire logic stepup_discharge_enable,
    // Output monitoring (comparators)
    input wire logic [2:0] above_low_level,
    input wire logic [2:0] above_uv,
    input wire logic [2:0] below_ov,
    input wire logic window_detect_sel,
    input wire logic [2:0] rise_mask,
    input wire logic [2:0] fall_mask,
    // Clock control
    input wire logic freq_dither_enable,
    input wire logic sync_enable,
    input wire logic [4:0] sync_nominal_freq,
    input wire logic sync_clock_input,
    input wire logic sync_mask,
    // Flag clears, one-cycle pulses
    input wire logic [2:0] good_flag_clear,
    input wire logic [2:0] short_flag_clear,
    input wire logic sync_flag_clear,
    // Outputs
    output logic [2:0] conv_enable,
    output logic stepup_pulldown,
    output logic [2:0] stepdown_valid_status,
    output logic [2:0] stepdown_good_flag,
    output logic [2:0] short_flag,
    output logic sync_flag,
    output logic use_sync_clock,
    output logic dither_active,
    output logic standby_reached,
    output logic interrupt_out
);
    localparam int MW = $clog2(MEAS_CYC + 1);
    localparam int EW = 16;
    localparam int CW = $clog2(CFG_CYC + 1);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    logic sync_prev_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_r <= 5'h00;
            sync_r <= 5'h00;
            sync_prev_r <= 1'b0;
        end else begin
            meta_r <= {sync_clock_input, reset_input_low, enable_pin_c,
                       enable_pin_b, enable_pin_a};
            sync_r <= meta_r;
            sync_prev_r <= sync_r[4];
        end
    end
    logic [2:0] pins_sync;
    assign pins_sync = sync_r[2:0];

    // ----------------------------------------
    // Operating state
    // ----------------------------------------
    cec_pkg::cec_state_t state_r;
    cec_pkg::cec_state_t state_nxt;
    logic [CW-1:0] cfg_cnt_r;
    logic [2:0] conv_on;
    logic any_on;
    logic allowed;
    assign any_on = |conv_on;
    assign allowed = (state_r == cec_pkg::ST_STANDBY)
                     || (state_r == cec_pkg::ST_ACTIVE);
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cec_pkg::ST_RESET: begin
                if (sync_r[3]) begin
                    state_nxt = cec_pkg::ST_CFG_READ;
                end
            end
            cec_pkg::ST_CFG_READ: begin
                if (cfg_cnt_r == CW'(CFG_CYC - 1)) begin
                    state_nxt = cec_pkg::ST_STANDBY;
                end
            end
            cec_pkg::ST_STANDBY: begin
                if (any_on) begin
                    state_nxt = cec_pkg::ST_ACTIVE;
                end
            end
            cec_pkg::ST_ACTIVE: begin
                if (!any_on) begin
                    state_nxt = cec_pkg::ST_STANDBY;
                end
            end
        endcase
        if (!sync_r[3]) begin
            state_nxt = cec_pkg::ST_RESET;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= cec_pkg::ST_RESET;
            cfg_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cfg_cnt_r <= (state_r == cec_pkg::ST_CFG_READ)
                         ? cfg_cnt_r + CW'(1) : '0;
        end
    end

    // ----------------------------------------
    // Converter controllers
    // ----------------------------------------
    logic [2:0] timeout;
    logic [2:0] on_bits;
    logic [5:0] selects;
    logic [11:0] on_dl;
    logic [11:0] off_dl;
    assign on_bits = {stepup_on_bit, stepdown_on_bit};
    assign selects = {stepup_pin_select, stepdown_pin_select};
    assign on_dl = {stepup_on_delay, stepdown_on_delay};
    assign off_dl = {stepup_off_delay, stepdown_off_delay};

    // ----------------------------------------
    // Power-good monitoring
    // ----------------------------------------
    logic [2:0] valid_now;
    logic [2:0] valid_prev_r;
    logic [2:0] good_set;
    logic [2:0] short_nxt;
    logic [2:0] good_nxt;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_conv
            cec_conv_ctrl #(
                .STEP_CYC(STEP_CYC),
                .TIMEOUT_CYC(TIMEOUT_CYC)
            ) u_ctrl (
                .clock(clock),
                .rst(rst),
                .allowed(allowed),
                .on_bit(on_bits[g]),
                .pin_select(selects[2*g+1:2*g]),
                .pins_sync(pins_sync),
                .on_delay(on_dl[4*g+3:4*g]),
                .off_delay(off_dl[4*g+3:4*g]),
                .above_level(above_low_level[g]),
                .conv_on(conv_on[g]),
                .timeout_pulse(timeout[g])
            );
            assign valid_now[g] = conv_on[g] && above_uv[g]
                                  && (!window_detect_sel || below_ov[g]);
            assign good_set[g] = (valid_now[g] && !valid_prev_r[g]
                                  && !rise_mask[g])
                                 || (!valid_now[g] && valid_prev_r[g]
                                  && !fall_mask[g]);
            assign good_nxt[g] = good_set[g]
                                 || (stepdown_good_flag[g]
                                     && !good_flag_clear[g]);
            assign short_nxt[g] = timeout[g]
                                  || (short_flag[g] && !short_flag_clear[g]);
        end
    endgenerate

    // ----------------------------------------
    // Sync clock detector
    // ----------------------------------------
    logic [MW-1:0] meas_cnt_r;
    logic [EW-1:0] edge_cnt_r;
    logic [EW-1:0] exp_edges;
    logic [EW-1:0] lo_edges;
    logic [EW-1:0] hi_edges;
    logic meas_done;
    logic clk_ok_r;
    logic clk_ok_nxt;
    logic sync_edge;
    logic sync_set;
    logic sync_nxt;
    logic enter_standby;
    logic enter_active;
    // Expected edges per window: MHz times microseconds.
    assign exp_edges = EW'(32'(sync_nominal_freq) * MEAS_CYC
                           / (cec_pkg::CLK_HZ / 1000000));
    assign lo_edges = EW'(32'(exp_edges) * cec_pkg::FREQ_LO_PCT / 100);
    assign hi_edges = EW'(32'(exp_edges) * cec_pkg::FREQ_HI_PCT / 100);
    assign sync_edge = sync_r[4] && !sync_prev_r;
    assign meas_done = (meas_cnt_r == MW'(MEAS_CYC - 1));
    assign clk_ok_nxt = (edge_cnt_r >= lo_edges)
                        && (edge_cnt_r <= hi_edges)
                        && (sync_nominal_freq != 5'h00);
    assign enter_standby = (state_r == cec_pkg::ST_CFG_READ)
                           && (state_nxt == cec_pkg::ST_STANDBY);
    assign enter_active = (state_r == cec_pkg::ST_STANDBY)
                          && (state_nxt == cec_pkg::ST_ACTIVE);
    assign sync_set = sync_enable
                      && ((meas_done && (clk_ok_nxt != clk_ok_r))
                          || ((enter_standby || enter_active)
                              && !clk_ok_r));
    assign sync_nxt = sync_set || (sync_flag && !sync_flag_clear);

    always_ff @(posedge clock) begin
        if (rst) begin
            meas_cnt_r <= '0;
            edge_cnt_r <= '0;
            clk_ok_r <= 1'b0;
        end else if (!sync_enable) begin
            meas_cnt_r <= '0;
            edge_cnt_r <= '0;
            clk_ok_r <= 1'b0;
        end else begin
            meas_cnt_r <= meas_done ? '0 : meas_cnt_r + MW'(1);
            if (meas_done) begin
                edge_cnt_r <= '0;
                clk_ok_r <= clk_ok_nxt;
            end else if (sync_edge && edge_cnt_r != '1) begin
                edge_cnt_r <= edge_cnt_r + EW'(1);
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            valid_prev_r <= 3'h0;
            conv_enable <= 3'h0;
            stepup_pulldown <= cec_pkg::STEPUP_DISCHARGE_RESET;
            stepdown_valid_status <= 3'h0;
            stepdown_good_flag <= 3'h0;
            short_flag <= 3'h0;
            sync_flag <= 1'b0;
            use_sync_clock <= 1'b0;
            dither_active <= 1'b0;
            standby_reached <= 1'b0;
            interrupt_out <= 1'b0;
        end else begin
            valid_prev_r <= valid_now;
            conv_enable <= conv_on;
            stepup_pulldown <= stepup_discharge_enable && !conv_on[2];
            stepdown_valid_status <= valid_now;
            stepdown_good_flag <= good_nxt;
            short_flag <= short_nxt;
            sync_flag <= sync_nxt;
            use_sync_clock <= sync_enable && clk_ok_r;
            dither_active <= freq_dither_enable && !sync_enable;
            standby_reached <= allowed;
            interrupt_out <= (|good_nxt) || (|short_nxt)
                             || (sync_nxt && !sync_mask);
        end
    end
endmodule // cec_top
`default_nettype wire

// file: verif/cec_plant.sv
// Behavioural model of the three converter outputs and their comparators.
`timescale 1ns/1ns
`default_nettype none
module cec_plant (
    // Clock
    input wire logic clock,
    // Enables and fault commands
    input wire logic [2:0] conv_enable,
    input wire logic [2:0] short_cmd,
    input wire logic [2:0] over_cmd,
    // Comparator levels
    output logic [2:0] above_low_level = 3'h0,
    output logic [2:0] above_uv = 3'h0,
    output logic [2:0] below_ov = 3'h7
);
    logic [3:0] age_r [3] = '{4'h0, 4'h0, 4'h0};
    always @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            if (conv_enable[i] !== 1'b1 || short_cmd[i]) begin
                age_r[i] <= 4'h0;
            end else if (age_r[i] != 4'hF) begin
                age_r[i] <= age_r[i] + 4'h1;
            end
            above_low_level[i] <= age_r[i] >= 4'h2 && !short_cmd[i];
            above_uv[i] <= age_r[i] >= 4'h4 && !short_cmd[i];
            below_ov[i] <= !over_cmd[i];
        end
    end
endmodule // cec_plant
`default_nettype wire

// file: verif/cec_top_properties.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ns
`default_nettype none
module cec_checker #(
    parameter int TIMEOUT_CYC = 50
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Inputs
    input wire logic [1:0] stepdown_on_bit,
    input wire logic [3:0] stepdown_pin_select,
    input wire logic [2:0] above_low_level,
    input wire logic [2:0] above_uv,
    input wire logic window_detect_sel,
    input wire logic [2:0] rise_mask,
    input wire logic [2:0] good_flag_clear,
    input wire logic sync_enable,
    // Outputs
    input wire logic [2:0] conv_enable,
    input wire logic stepup_pulldown,
    input wire logic [2:0] stepdown_valid_status,
    input wire logic [2:0] stepdown_good_flag,
    input wire logic [2:0] short_flag,
    input wire logic sync_flag,
    input wire logic dither_active,
    input wire logic standby_reached,
    input wire logic interrupt_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    int unsigned wait_r;
    always_ff @(posedge clock) begin
        if (rst || !conv_enable[1] || above_low_level[1]) begin
            wait_r <= 0;
        end else begin
            wait_r <= wait_r + 1;
        end
    end
    a_bit_low_off: assert property (!stepdown_on_bit[0] ##1
        !stepdown_on_bit[0] |=> !conv_enable[0]) else $error("on while off");
    a_reg_on_fast: assert property ($rose(stepdown_on_bit[0]) &&
        stepdown_pin_select[1:0] == 2'h0 && standby_reached |-> ##2
        conv_enable[0]) else $error("register enable late");
    a_pre_standby_off: assert property ((!standby_reached)[*3] |->
        conv_enable == 3'h0) else $error("enabled outside standby");
    a_startup_bound: assert property (wait_r <= TIMEOUT_CYC + 2)
        else $error("start-up timeout missed");
    a_rise_flag_set: assert property ($rose(stepdown_valid_status[0]) &&
        !$past(rise_mask[0]) |-> stepdown_good_flag[0]) else $error("no flag");
    a_flag_cause: assert property ($rose(stepdown_good_flag[0]) |->
        $changed(stepdown_valid_status[0])) else $error("flag without change");
    a_flag_holds: assert property (stepdown_good_flag[0] &&
        !good_flag_clear[0] |=> stepdown_good_flag[0]) else $error("flag lost");
    a_status_follow: assert property (conv_enable[0] &&
        $past(above_uv[0]) && !$past(window_detect_sel) |->
        stepdown_valid_status[0]) else $error("status not valid");
    a_short_irq: assert property ((|short_flag) ##1 (|short_flag) |->
        interrupt_out) else $error("interrupt missing");
    a_sync_quiet: assert property (!sync_enable && !sync_flag |=>
        !sync_flag) else $error("sync flag while disabled");
    a_dither_block: assert property (sync_enable ##1 sync_enable |->
        !dither_active) else $error("dither with sync");
    a_boost_pulldown: assert property (conv_enable[2] ##1
        conv_enable[2] |-> !stepup_pulldown) else $error("pulldown while on");
endmodule // cec_checker
bind cec_top cec_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
    .clock(clock), .rst(rst), .stepdown_on_bit(stepdown_on_bit),
    .stepdown_pin_select(stepdown_pin_select),
    .above_low_level(above_low_level), .above_uv(above_uv),
    .window_detect_sel(window_detect_sel), .rise_mask(rise_mask),
    .good_flag_clear(good_flag_clear), .sync_enable(sync_enable),
    .conv_enable(conv_enable), .stepup_pulldown(stepup_pulldown),
    .stepdown_valid_status(stepdown_valid_status),
    .stepdown_good_flag(stepdown_good_flag), .short_flag(short_flag),
    .sync_flag(sync_flag), .dither_active(dither_active),
    .standby_reached(standby_reached), .interrupt_out(interrupt_out));
`default_nettype wire

// file: verif/cec_top_tb.sv
// Self-checking bench for the converter enable and clock control block.
`timescale 1ns/1ns
`default_nettype none
module cec_top_tb;
    localparam int STEP = 4;
    localparam int TMO = 50;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reset_input_low_pin_n = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [1:0] sd_on = 2'h0;
    logic [3:0] sd_sel = 4'h0;
    logic [7:0] ond = 8'h0;
    logic [7:0] offd = 8'h0;
    logic up_on = 1'b0;
    logic win = 1'b0;
    logic [2:0] rmsk = 3'h0;
    logic [2:0] fmsk = 3'h0;
    logic dith = 1'b0;
    logic sync_en = 1'b0;
    logic sync_msk = 1'b0;
    logic sync_clr = 1'b0;
    logic [2:0] gclr = 3'h0;
    logic [2:0] sclr = 3'h0;
    logic [2:0] shorts = 3'h0;
    logic [2:0] overs = 3'h0;
    logic dis = 1'b1;
    logic sclk_in = 1'b0;
    logic sclk_run = 1'b0;
    logic [4:0] sfreq = 5'h01;
    wire logic [2:0] low_ok, uv_ok, ov_ok, en, status, gflag, sflag;
    wire logic pulld, syncf, use_sync, dither, standby, irq;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    cec_top #(.STEP_CYC(STEP), .TIMEOUT_CYC(TMO), .MEAS_CYC(200),
        .CFG_CYC(64)) uut (
        .clock(clock), .rst(rst), .reset_input_low(reset_input_low_pin_n),
        .enable_pin_a(pins[0]), .enable_pin_b(pins[1]),
        .enable_pin_c(pins[2]), .stepdown_on_bit(sd_on),
        .stepdown_pin_select(sd_sel), .stepdown_on_delay(ond),
        .stepdown_off_delay(offd), .stepup_on_bit(up_on),
        .stepup_pin_select(2'h0), .stepup_on_delay(4'h0),
        .stepup_off_delay(4'h0), .stepup_discharge_enable(dis),
        .above_low_level(low_ok), .above_uv(uv_ok), .below_ov(ov_ok),
        .window_detect_sel(win), .rise_mask(rmsk), .fall_mask(fmsk),
        .freq_dither_enable(dith), .sync_enable(sync_en),
        .sync_nominal_freq(sfreq), .sync_clock_input(sclk_in),
        .sync_mask(sync_msk), .good_flag_clear(gclr),
        .short_flag_clear(sclr), .sync_flag_clear(sync_clr),
        .conv_enable(en), .stepup_pulldown(pulld),
        .stepdown_valid_status(status), .stepdown_good_flag(gflag),
        .short_flag(sflag), .sync_flag(syncf), .use_sync_clock(use_sync),
        .dither_active(dither), .standby_reached(standby),
        .interrupt_out(irq));
    cec_plant u_plant (.clock(clock), .conv_enable(en), .short_cmd(shorts),
        .over_cmd(overs), .above_low_level(low_ok), .above_uv(uv_ok),
        .below_ov(ov_ok));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic clr_all;
        gclr = 3'h7;
        sclr = 3'h7;
        sync_clr = 1'b1;
        cyc(1);
        gclr = 3'h0;
        sclr = 3'h0;
        sync_clr = 1'b0;
        cyc(2);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic t_power;
        sd_on = 2'h1;
        cyc(2);
        rst = 1'b0;
        cyc(10);
        chk(en, 3'h0);
        chk(pulld, 1'b1);
        sd_on = 2'h0;
        reset_input_low_pin_n = 1'b1;
        cyc(60);
        chk(standby, 1'b0);
        cyc(15);
        chk(standby, 1'b1);
        cyc(23925);
        $display("test power done");
    endtask
    task automatic t_reg;
        ond = 8'hFF;
        sd_on = 2'h1;
        up_on = 1'b1;
        cyc(3);
        chk(en, 3'h5);
        chk(pulld, 1'b0);
        sd_on = 2'h0;
        up_on = 1'b0;
        cyc(3);
        chk(en, 3'h0);
        chk(pulld, 1'b1);
        dis = 1'b0;
        cyc(2);
        chk(pulld, 1'b0);
        $display("test register enable done");
    endtask
    task automatic t_pins;
        ond = 8'h02;
        offd = 8'h03;
        sd_on = 2'h1;
        for (int k = 1; k < 4; k++) begin
            sd_sel = {2'h0, k[1:0]};
            pins = 3'h7 ^ (3'h1 << (k - 1));
            cyc(20);
            chk(en[0], 1'b0);
            pins = 3'h7;
            cyc(6);
            chk(en[0], 1'b0);
            cyc(14);
            chk(en[0], 1'b1);
            pins = 3'h0;
            cyc(8);
            chk(en[0], 1'b1);
            cyc(17);
            chk(en[0], 1'b0);
        end
        pins = 3'h7;
        sd_on = 2'h0;
        cyc(30);
        chk(en[0], 1'b0);
        pins = 3'h0;
        sd_sel = 4'h0;
        $display("test pin enable done");
    endtask
    task automatic t_short;
        clr_all();
        shorts = 3'h2;
        sd_on = 2'h2;
        cyc(TMO + 8);
        chk(en[1], 1'b0);
        chk(sflag[1], 1'b1);
        chk(irq, 1'b1);
        sd_on = 2'h0;
        shorts = 3'h0;
        clr_all();
        chk(sflag[1], 1'b0);
        chk(irq, 1'b0);
        $display("test short done");
    endtask
    task automatic t_good;
        rmsk = 3'h1;
        sd_on = 2'h1;
        cyc(12);
        chk(status[0], 1'b1);
        chk(gflag[0], 1'b0);
        overs = 3'h1;
        cyc(4);
        chk(status[0], 1'b1);
        win = 1'b1;
        cyc(4);
        chk(status[0], 1'b0);
        chk(gflag[0], 1'b1);
        chk(irq, 1'b1);
        clr_all();
        chk(gflag[0], 1'b0);
        fmsk = 3'h1;
        overs = 3'h0;
        cyc(4);
        chk(status[0], 1'b1);
        chk(gflag[0], 1'b0);
        overs = 3'h1;
        cyc(4);
        chk(gflag[0], 1'b0);
        chk(status[0], 1'b0);
        overs = 3'h0;
        rmsk = 3'h0;
        fmsk = 3'h0;
        win = 1'b0;
        cyc(4);
        chk(gflag[0], 1'b1);
        sd_on = 2'h0;
        cyc(4);
        $display("test power good done");
    endtask
    task automatic t_clock;
        rmsk = 3'h7;
        fmsk = 3'h7;
        clr_all();
        dith = 1'b1;
        sd_on = 2'h1;
        cyc(30);
        chk(dither, 1'b1);
        chk(use_sync, 1'b0);
        chk(syncf, 1'b0);
        sd_on = 2'h0;
        sync_en = 1'b1;
        sync_msk = 1'b1;
        cyc(4);
        chk(dither, 1'b0);
        sd_on = 2'h1;
        cyc(8);
        chk(syncf, 1'b1);
        chk(use_sync, 1'b0);
        chk(irq, 1'b0);
        sync_msk = 1'b0;
        cyc(3);
        chk(irq, 1'b1);
        sd_on = 2'h0;
        sync_en = 1'b0;
        clr_all();
        chk(syncf, 1'b0);
        $display("test clock done");
    endtask
    task automatic t_sync;
        sync_en = 1'b1;
        sclk_run = 1'b1;
        cyc(450);
        chk(use_sync, 1'b1);
        chk(syncf, 1'b1);
        clr_all();
        sclk_run = 1'b0;
        cyc(450);
        chk(use_sync, 1'b0);
        chk(syncf, 1'b1);
        clr_all();
        sfreq = 5'h02;
        sclk_run = 1'b1;
        cyc(450);
        chk(use_sync, 1'b0);
        chk(syncf, 1'b0);
        $display("test sync done");
    endtask
    always @(negedge clock) begin
        if (sclk_run && cycles % 10 == 0) begin
            sclk_in = ~sclk_in;
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        t_power();
        t_reg();
        t_pins();
        t_short();
        t_good();
        t_clock();
        t_sync();
        summarize();
    end
endmodule // cec_top_tb
`default_nettype wire
